// *** rtl/tev_pkg.sv ***
// package: timer-event register numbers, field layout, reset values and carriers
package tev_pkg;
   // special-purpose register numbers
   localparam logic [9:0] SPR_STATUS = 10'h3d8;
   localparam logic [9:0] SPR_CONTROL = 10'h3da;
   localparam logic [9:0] SPR_COUNTDOWN = 10'h3db;
   // printed bit 0 is the msb, so printed bit n sits at vector index 31-n
   localparam int CTL_TOP = 31;
   localparam int CTL_W = 10;
   localparam int STS_TOP = 31;
   localparam int STS_W = 6;
   localparam int STS_ARM_BIT = 31;
   localparam int STS_SEEN_BIT = 30;
   localparam int STS_WRS_HI = 29;
   localparam int STS_WRS_LO = 28;
   localparam int STS_INTERVAL_BIT = 27;
   localparam int STS_FIXED_BIT = 26;
   // reset values
   localparam logic [CTL_W-1:0] CTL_RESET = 10'h000;
   localparam logic [STS_W-1:0] STS_RESET = 6'h00;
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] ONE_WORD = 32'h0000_0001;
   localparam logic [1:0] RESET_NONE = 2'h0;
   // time-base low word taps: watchdog 2^17..2^29, fixed interval 2^9..2^21
   localparam logic [4:0] WD_TAP0 = 5'h10;
   localparam logic [4:0] WD_TAP1 = 5'h14;
   localparam logic [4:0] WD_TAP2 = 5'h18;
   localparam logic [4:0] WD_TAP3 = 5'h1c;
   localparam logic [4:0] FIX_TAP0 = 5'h08;
   localparam logic [4:0] FIX_TAP1 = 5'h0c;
   localparam logic [4:0] FIX_TAP2 = 5'h10;
   localparam logic [4:0] FIX_TAP3 = 5'h14;

   typedef struct packed {
      logic [1:0] watchdog_period_sel;
      logic [1:0] watchdog_reset_kind;
      logic watchdog_irq_enable;
      logic interval_irq_enable;
      logic [1:0] fixed_period_sel;
      logic fixed_irq_enable;
      logic auto_reload_enable;
   } tev_ctrl_s;

   typedef struct packed {
      logic next_watchdog_armed;
      logic watchdog_irq_seen;
      logic [1:0] watchdog_reset_record;
      logic interval_irq_status;
      logic fixed_irq_status;
   } tev_status_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic priv;
      logic [9:0] num;
      logic [31:0] wdata;
   } tev_spr_req_s;

   // watchdog progress, gray along quiet -> armed -> seen
   typedef enum logic [1:0] {
      WD_QUIET = 2'b00,
      WD_ARMED = 2'b01,
      WD_SEEN = 2'b11
   } tev_wd_e;
endpackage

// *** rtl/tev_tap_rise.sv ***
// module: rising-edge detector on a selectable bit of the time-base low word
`timescale 1ns/1ps
module tev_tap_rise #(
   parameter logic [4:0] TAP0 = 5'h00,
   parameter logic [4:0] TAP1 = 5'h00,
   parameter logic [4:0] TAP2 = 5'h00,
   parameter logic [4:0] TAP3 = 5'h00
) (
   input wire logic mclk, // core clock
   input wire logic rst_b, // async reset, active low
   input wire logic [31:0] word, // time-base low word
   input wire logic [1:0] sel, // tap selection code
   output logic rise // one-cycle pulse on 0->1 of the tap
);
   logic [4:0] idx;
   logic bit_now;
   logic bit_prev_reg;

   always_comb begin
      case (sel)
         2'd0: idx = TAP0;
         2'd1: idx = TAP1;
         2'd2: idx = TAP2;
         default: idx = TAP3;
      endcase
   end

   assign bit_now = word[idx];

   // changing sel may show one spurious edge; software sets periods before use
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bit_prev_reg <= 1'b1; // a tap already high as reset lifts is no timeout
         rise <= 1'b0;
      end else begin
         bit_prev_reg <= bit_now;
         rise <= bit_now & ~bit_prev_reg;
      end
   end
endmodule

// *** rtl/tev_countdown.sv ***
// module: 32-bit interval down-counter with hidden reload value
`timescale 1ns/1ps
module tev_countdown (
   input wire logic mclk, // core clock
   input wire logic rst_b, // async reset, active low
   input wire logic tick, // time-base rate enable
   input wire logic load, // software write strobe
   input wire logic [31:0] load_val, // written value
   input wire logic auto_reload, // reload instead of stopping
   output logic [31:0] count, // live counter value
   output logic evt // one-cycle pulse after 1 is decremented
);
   logic [31:0] reload_reg;
   logic [31:0] interval_countdown_reg;
   logic [31:0] interval_countdown_next;
   logic expire;

   assign expire = tick && !load && interval_countdown_reg == tev_pkg::ONE_WORD;

   always_comb begin
      interval_countdown_next = interval_countdown_reg;
      if (load) begin
         interval_countdown_next = load_val;
      end else if (expire) begin
         interval_countdown_next = auto_reload ? reload_reg : tev_pkg::ZERO_WORD;
      end else if (tick && interval_countdown_reg != tev_pkg::ZERO_WORD) begin
         interval_countdown_next = interval_countdown_reg - tev_pkg::ONE_WORD;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         interval_countdown_reg <= tev_pkg::COUNT_RESET;
         reload_reg <= tev_pkg::COUNT_RESET;
      end else begin
         interval_countdown_reg <= interval_countdown_next;
         if (load) begin
            reload_reg <= load_val;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         evt <= 1'b0;
      end else begin
         evt <= expire;
      end
   end

   assign count = interval_countdown_reg;
endmodule

// *** rtl/tev_timer_events.sv ***
// module: timer-event registers with countdown, control, status and watchdog steps
`timescale 1ns/1ps
module tev_timer_events (
   input wire logic mclk, // core clock, 100 MHz
   input wire logic rst_b, // async reset, active low
   input wire tev_pkg::tev_spr_req_s spr_req, // special-purpose register access
   input wire logic [31:0] timebase_low_word, // time-base low word
   input wire logic timebase_tick, // one-cycle pulse per time-base step
   output logic [31:0] spr_rdata, // read data, one cycle after rd
   output logic spr_rvalid, // pulse marking spr_rdata
   output logic spr_priv_fault, // pulse: unprivileged access to a timer register
   output logic irq_watchdog, // watchdog interrupt request, level
   output logic irq_interval, // interval countdown interrupt request, level
   output logic irq_fixed, // fixed-interval interrupt request, level
   output logic [1:0] wd_reset_req // one-cycle pulse with forced reset kind
);
   // ------------------------------------------------------------
   // register access decode
   // ------------------------------------------------------------
   tev_pkg::tev_ctrl_s timer_control_reg;
   tev_pkg::tev_ctrl_s ctrl_wr;
   tev_pkg::tev_status_s timer_status_reg;
   tev_pkg::tev_status_s sts_clr;
   tev_pkg::tev_wd_e wd_state;
   logic hit_sts;
   logic hit_ctl;
   logic hit_cnt;
   logic hit_any;
   logic wr_ok;
   logic wr_sts;
   logic wr_ctl;
   logic wr_cnt;
   logic [31:0] count;
   logic cnt_evt;
   logic fix_evt;
   logic wd_to;
   logic wd_force;

   assign hit_sts = spr_req.num == tev_pkg::SPR_STATUS;
   assign hit_ctl = spr_req.num == tev_pkg::SPR_CONTROL;
   assign hit_cnt = spr_req.num == tev_pkg::SPR_COUNTDOWN;
   assign hit_any = hit_sts | hit_ctl | hit_cnt;
   // unprivileged accesses change nothing and read back zero
   assign wr_ok = spr_req.wr & spr_req.priv;
   assign wr_sts = wr_ok & hit_sts;
   assign wr_ctl = wr_ok & hit_ctl;
   assign wr_cnt = wr_ok & hit_cnt;

   assign ctrl_wr = spr_req.wdata[tev_pkg::CTL_TOP -: tev_pkg::CTL_W];
   assign sts_clr = wr_sts ? spr_req.wdata[tev_pkg::STS_TOP -: tev_pkg::STS_W]
                           : tev_pkg::STS_RESET;

   // ------------------------------------------------------------
   // interval countdown and period taps
   // ------------------------------------------------------------
   tev_countdown u_countdown (
      .mclk(mclk),
      .rst_b(rst_b),
      .tick(timebase_tick),
      .load(wr_cnt),
      .load_val(spr_req.wdata),
      .auto_reload(timer_control_reg.auto_reload_enable),
      .count(count),
      .evt(cnt_evt)
   );

   tev_tap_rise #(
      .TAP0(tev_pkg::WD_TAP0),
      .TAP1(tev_pkg::WD_TAP1),
      .TAP2(tev_pkg::WD_TAP2),
      .TAP3(tev_pkg::WD_TAP3)
   ) u_wd_tap (
      .mclk(mclk),
      .rst_b(rst_b),
      .word(timebase_low_word),
      .sel(timer_control_reg.watchdog_period_sel),
      .rise(wd_to)
   );

   tev_tap_rise #(
      .TAP0(tev_pkg::FIX_TAP0),
      .TAP1(tev_pkg::FIX_TAP1),
      .TAP2(tev_pkg::FIX_TAP2),
      .TAP3(tev_pkg::FIX_TAP3)
   ) u_fix_tap (
      .mclk(mclk),
      .rst_b(rst_b),
      .word(timebase_low_word),
      .sel(timer_control_reg.fixed_period_sel),
      .rise(fix_evt)
   );

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         timer_control_reg <= tev_pkg::CTL_RESET;
      end else if (wr_ctl) begin
         timer_control_reg.watchdog_period_sel <= ctrl_wr.watchdog_period_sel;
         // ored in so errant code cannot switch watchdog resets off
         timer_control_reg.watchdog_reset_kind <=
            timer_control_reg.watchdog_reset_kind | ctrl_wr.watchdog_reset_kind;
         timer_control_reg.watchdog_irq_enable <= ctrl_wr.watchdog_irq_enable;
         timer_control_reg.interval_irq_enable <= ctrl_wr.interval_irq_enable;
         timer_control_reg.fixed_period_sel <= ctrl_wr.fixed_period_sel;
         timer_control_reg.fixed_irq_enable <= ctrl_wr.fixed_irq_enable;
         timer_control_reg.auto_reload_enable <= ctrl_wr.auto_reload_enable;
      end
   end

   // ------------------------------------------------------------
   // watchdog steps
   // ------------------------------------------------------------
   always_comb begin
      case ({timer_status_reg.watchdog_irq_seen, timer_status_reg.next_watchdog_armed})
         2'b01: wd_state = tev_pkg::WD_ARMED;
         2'b11: wd_state = tev_pkg::WD_SEEN;
         // seen without armed is ignored until armed again
         default: wd_state = tev_pkg::WD_QUIET;
      endcase
   end

   always_comb begin
      case (wd_state)
         tev_pkg::WD_SEEN: wd_force = wd_to &&
            timer_control_reg.watchdog_reset_kind != tev_pkg::RESET_NONE;
         default: wd_force = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wd_reset_req <= tev_pkg::RESET_NONE;
      end else begin
         wd_reset_req <= wd_force ? timer_control_reg.watchdog_reset_kind
                                  : tev_pkg::RESET_NONE;
      end
   end

   // ------------------------------------------------------------
   // status register: set wins over a clear in the same cycle
   // ------------------------------------------------------------
   // one process owns the whole status word so no field has a second driver
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         timer_status_reg <= tev_pkg::STS_RESET;
      end else begin
         timer_status_reg.next_watchdog_armed <= wd_to |
            (timer_status_reg.next_watchdog_armed & ~sts_clr.next_watchdog_armed);
         timer_status_reg.watchdog_irq_seen <= (wd_to & wd_state != tev_pkg::WD_QUIET) |
            (timer_status_reg.watchdog_irq_seen & ~sts_clr.watchdog_irq_seen);
         if (wd_force) begin
            timer_status_reg.watchdog_reset_record <= timer_control_reg.watchdog_reset_kind;
         end else begin
            timer_status_reg.watchdog_reset_record <= timer_status_reg.watchdog_reset_record &
               ~sts_clr.watchdog_reset_record;
         end
         timer_status_reg.interval_irq_status <= cnt_evt |
            (timer_status_reg.interval_irq_status & ~sts_clr.interval_irq_status);
         timer_status_reg.fixed_irq_status <= fix_evt |
            (timer_status_reg.fixed_irq_status & ~sts_clr.fixed_irq_status);
      end
   end

   // ------------------------------------------------------------
   // interrupt requests; the core applies its own critical enable
   // ------------------------------------------------------------
   assign irq_watchdog = timer_status_reg.watchdog_irq_seen &
                         timer_status_reg.next_watchdog_armed &
                         timer_control_reg.watchdog_irq_enable;
   assign irq_interval = timer_status_reg.interval_irq_status &
                         timer_control_reg.interval_irq_enable;
   assign irq_fixed = timer_status_reg.fixed_irq_status &
                      timer_control_reg.fixed_irq_enable;

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         spr_rdata <= tev_pkg::ZERO_WORD;
         spr_rvalid <= 1'b0;
         spr_priv_fault <= 1'b0;
      end else begin
         spr_rvalid <= spr_req.rd;
         spr_priv_fault <= (spr_req.rd | spr_req.wr) & ~spr_req.priv & hit_any;
         spr_rdata <= tev_pkg::ZERO_WORD;
         if (spr_req.rd && spr_req.priv) begin
            if (hit_cnt) begin
               spr_rdata <= count;
            end else if (hit_ctl) begin
               spr_rdata[tev_pkg::CTL_TOP -: tev_pkg::CTL_W] <= timer_control_reg;
            end else if (hit_sts) begin
               spr_rdata[tev_pkg::STS_TOP -: tev_pkg::STS_W] <= timer_status_reg;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence s_armed_timeout;
      wd_to && wd_state == tev_pkg::WD_ARMED;
   endsequence

   sequence s_seen_timeout;
      wd_to && wd_state == tev_pkg::WD_SEEN &&
         timer_control_reg.watchdog_reset_kind != tev_pkg::RESET_NONE;
   endsequence

   a_count_step: assert property (
      timebase_tick && !wr_cnt && count > tev_pkg::ONE_WORD
      |=> count == $past(count) - tev_pkg::ONE_WORD)
      else $error("countdown did not step down by one");

   a_count_hold: assert property (
      count == tev_pkg::ZERO_WORD && !wr_cnt |=> count == tev_pkg::ZERO_WORD)
      else $error("countdown left zero without a write");

   a_count_expire: assert property (
      timebase_tick && !wr_cnt && count == tev_pkg::ONE_WORD
      |=> cnt_evt ##1 timer_status_reg.interval_irq_status)
      else $error("interval event or status missing after expiry");

   a_reset_sticky: assert property (
      (timer_control_reg.watchdog_reset_kind & $past(timer_control_reg.watchdog_reset_kind))
      == $past(timer_control_reg.watchdog_reset_kind))
      else $error("watchdog reset kind bit was cleared");

   a_status_clear: assert property (
      wr_sts && spr_req.wdata[tev_pkg::STS_INTERVAL_BIT] && !cnt_evt
      |=> !timer_status_reg.interval_irq_status)
      else $error("clear mask did not clear interval status");

   a_status_keep: assert property (
      $fell(timer_status_reg.fixed_irq_status)
      |-> $past(wr_sts && spr_req.wdata[tev_pkg::STS_FIXED_BIT]))
      else $error("fixed status dropped without a clear");

   a_wd_arm: assert property (
      wd_to && wd_state == tev_pkg::WD_QUIET
      |=> timer_status_reg.next_watchdog_armed && wd_reset_req == tev_pkg::RESET_NONE)
      else $error("first timeout did not only arm");

   a_wd_seen: assert property (s_armed_timeout |=> timer_status_reg.watchdog_irq_seen)
      else $error("armed timeout did not record interrupt");

   a_wd_force: assert property (
      s_seen_timeout |=> wd_reset_req == $past(timer_control_reg.watchdog_reset_kind)
      ##0 timer_status_reg.watchdog_reset_record == wd_reset_req ##1
      wd_reset_req == tev_pkg::RESET_NONE)
      else $error("forced reset kind or record wrong");

   a_irq_interval: assert property (
      cnt_evt && timer_control_reg.interval_irq_enable && !wr_ctl |=> irq_interval)
      else $error("interval interrupt not raised");

   a_unpriv_read: assert property (
      spr_req.rd && !spr_req.priv && hit_cnt
      |=> spr_rvalid && spr_priv_fault && spr_rdata == tev_pkg::ZERO_WORD)
      else $error("unprivileged read was answered");

   a_count_load: assert property (
      wr_cnt |=> count == $past(spr_req.wdata))
      else $error("countdown write did not load the counter");

   a_reload_nonzero: assert property (
      timer_control_reg.auto_reload_enable && count != tev_pkg::ZERO_WORD && !wr_cnt
      |=> count != tev_pkg::ZERO_WORD)
      else $error("auto-reload countdown reached zero");

   sequence s_reload_expiry;
      timebase_tick && !wr_cnt && count == tev_pkg::ONE_WORD &&
         timer_control_reg.auto_reload_enable;
   endsequence

   a_reload_event: assert property (
      s_reload_expiry |=> cnt_evt && count != tev_pkg::ZERO_WORD)
      else $error("reload expiry lost its event or value");

   a_wd_irq: assert property (
      s_armed_timeout ##0 (timer_control_reg.watchdog_irq_enable && !wr_ctl) |=> irq_watchdog)
      else $error("watchdog interrupt not raised");

   a_fixed_irq: assert property (
      fix_evt && timer_control_reg.fixed_irq_enable && !wr_ctl |=> irq_fixed)
      else $error("fixed-interval interrupt not raised");

   a_quiet_hold: assert property (
      wd_to && wd_state == tev_pkg::WD_QUIET && !wr_sts
      |=> $stable(timer_status_reg.watchdog_irq_seen))
      else $error("disarmed timeout touched the seen flag");

   a_ctl_unpriv: assert property (
      spr_req.wr && !spr_req.priv && hit_ctl |=> $stable(timer_control_reg))
      else $error("unprivileged write changed control");

   // reserved bits are checked by shifting the live field out of the word
   a_ctl_reserved: assert property (
      spr_req.rd && spr_req.priv && hit_ctl
      |=> (spr_rdata << tev_pkg::CTL_W) == tev_pkg::ZERO_WORD)
      else $error("reserved control bits read non-zero");

   a_sts_reserved: assert property (
      spr_req.rd && spr_req.priv && hit_sts
      |=> (spr_rdata << tev_pkg::STS_W) == tev_pkg::ZERO_WORD)
      else $error("reserved status bits read non-zero");

   a_record_keep: assert property (
      $changed(timer_status_reg.watchdog_reset_record) |-> $past(wd_force || wr_sts))
      else $error("reset record changed with no cause");
endmodule

// *** bench/timer_event_registers_tb.sv ***
// testbench: timer-event registers compared with a behavioural model
`timescale 1ns/1ps
module timer_event_registers_tb;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   tev_pkg::tev_spr_req_s req = '0;
   logic [31:0] tb_word = 32'h0000_0000;
   logic tb_tick = 1'b0;
   logic [31:0] rdata;
   logic rvalid, fault, irq_wd, irq_int, irq_fix;
   logic [1:0] wd_req;
   int mismatches = 0;
   int compares = 0;
   int seed = 32'hf5cc;
   logic [31:0] m_ctl, m_sts, m_cnt, m_rld, got;
   logic flt;

   tev_timer_events uut (.mclk(mclk), .rst_b(rst_b), .spr_req(req),
      .timebase_low_word(tb_word), .timebase_tick(tb_tick), .spr_rdata(rdata),
      .spr_rvalid(rvalid), .spr_priv_fault(fault), .irq_watchdog(irq_wd),
      .irq_interval(irq_int), .irq_fixed(irq_fix), .wd_reset_req(wd_req));

   always #5 mclk = ~mclk;

   // ---------------------------------------------------------------
   // compare and report
   // ---------------------------------------------------------------
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic seen);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %b seen %b", what, exp, seen);
      end
   endtask

   initial begin
      #200000;
      mismatches++;
      $display("[ERR] run expected done seen timeout");
      tally_and_finish;
   end

   // ---------------------------------------------------------------
   // register access, one idle cycle after each so strobes never double up
   // ---------------------------------------------------------------
   task automatic spr_wr(input logic [9:0] num, input logic [31:0] d, input logic priv);
      req.wr = 1'b1;
      req.priv = priv;
      req.num = num;
      req.wdata = d;
      @(negedge mclk);
      req.wr = 1'b0;
      @(negedge mclk);
      if (priv && num == tev_pkg::SPR_CONTROL) begin
         m_ctl = {d[31:30], d[29:28] | m_ctl[29:28], d[27:22], 22'h0};
      end else if (priv && num == tev_pkg::SPR_COUNTDOWN) begin
         m_cnt = d;
         m_rld = d;
      end else if (priv && num == tev_pkg::SPR_STATUS) begin
         m_sts = m_sts & ~d;
      end
   endtask

   task automatic spr_rd(input logic [9:0] num, input logic priv);
      req.rd = 1'b1;
      req.priv = priv;
      req.num = num;
      @(negedge mclk);
      req.rd = 1'b0;
      for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge mclk);
      if (rvalid !== 1'b1) begin
         mismatches++;
         $display("[ERR] spr_rvalid expected 1 seen %b", rvalid);
         tally_and_finish;
      end
      got = rdata;
      flt = fault;
      @(negedge mclk);
   endtask

   task automatic rd_chk(input string what, input logic [9:0] num, input logic [31:0] exp);
      spr_rd(num, 1'b1);
      chk_word(what, exp, got);
   endtask

   task automatic chk_irqs;
      chk_bit("irq_watchdog", m_sts[31] & m_sts[30] & m_ctl[27], irq_wd);
      chk_bit("irq_interval", m_sts[27] & m_ctl[26], irq_int);
      chk_bit("irq_fixed", m_sts[26] & m_ctl[23], irq_fix);
   endtask

   task automatic tick;
      tb_tick = 1'b1;
      @(negedge mclk);
      tb_tick = 1'b0;
      if (m_cnt == 32'h0000_0001) begin
         m_sts[27] = 1'b1;
         m_cnt = m_ctl[22] ? m_rld : 32'h0000_0000;
      end else if (m_cnt != 32'h0000_0000) begin
         m_cnt = m_cnt - 32'h0000_0001;
      end
      repeat (2) @(negedge mclk);
   endtask

   // raise one time-base bit and catch any forced reset pulse
   task automatic rise(input int b);
      logic [1:0] pulse;
      logic [1:0] exp;
      pulse = 2'b00;
      exp = 2'b00;
      tb_word[b] = 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(negedge mclk);
         if (wd_req !== 2'b00) pulse = wd_req;
      end
      tb_word[b] = 1'b0;
      repeat (3) @(negedge mclk);
      if (b == 8) m_sts[26] = 1'b1;
      else if (!m_sts[31]) m_sts[31] = 1'b1;
      else if (!m_sts[30]) m_sts[30] = 1'b1;
      else if (m_ctl[29:28] != 2'b00) begin
         exp = m_ctl[29:28];
         m_sts[29:28] = exp;
      end
      chk_word("wd_reset_req", {30'h0, exp}, {30'h0, pulse});
      rd_chk("status", tev_pkg::SPR_STATUS, m_sts);
      chk_irqs;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      m_ctl = '0;
      m_sts = '0;
      m_cnt = '0;
      m_rld = '0;
      repeat (3) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      rd_chk("status", tev_pkg::SPR_STATUS, m_sts);
      rd_chk("control", tev_pkg::SPR_CONTROL, m_ctl);
      rd_chk("countdown", tev_pkg::SPR_COUNTDOWN, m_cnt);
      rd_chk("unmapped", 10'h3d9, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         spr_wr(tev_pkg::SPR_CONTROL, $random(seed), 1'b1);
         rd_chk("control", tev_pkg::SPR_CONTROL, m_ctl);
      end
      spr_wr(tev_pkg::SPR_COUNTDOWN, $random(seed), 1'b1);
      tick;
      rd_chk("countdown", tev_pkg::SPR_COUNTDOWN, m_cnt);
      spr_wr(tev_pkg::SPR_CONTROL, 32'hffc0_0000, 1'b0);
      spr_rd(tev_pkg::SPR_CONTROL, 1'b0);
      chk_word("control unpriv", 32'h0000_0000, got);
      chk_bit("spr_priv_fault", 1'b1, flt);
      rd_chk("control", tev_pkg::SPR_CONTROL, m_ctl);
      // one-shot countdown with interrupt enabled
      spr_wr(tev_pkg::SPR_CONTROL, 32'h0400_0000, 1'b1);
      spr_wr(tev_pkg::SPR_COUNTDOWN, 32'h0000_0003, 1'b1);
      for (int i = 0; i < 4; i++) begin
         tick;
         rd_chk("countdown", tev_pkg::SPR_COUNTDOWN, m_cnt);
      end
      rd_chk("status", tev_pkg::SPR_STATUS, m_sts);
      chk_irqs;
      spr_wr(tev_pkg::SPR_STATUS, 32'h0000_0000, 1'b1);
      rd_chk("status", tev_pkg::SPR_STATUS, m_sts);
      spr_wr(tev_pkg::SPR_STATUS, 32'h0800_0000, 1'b1);
      rd_chk("status", tev_pkg::SPR_STATUS, m_sts);
      chk_irqs;
      // auto-reload, interrupt masked so the bit only shows pending
      spr_wr(tev_pkg::SPR_CONTROL, 32'h0040_0000, 1'b1);
      spr_wr(tev_pkg::SPR_COUNTDOWN, 32'h0000_0002, 1'b1);
      for (int i = 0; i < 5; i++) begin
         tick;
         rd_chk("countdown", tev_pkg::SPR_COUNTDOWN, m_cnt);
      end
      rd_chk("status", tev_pkg::SPR_STATUS, m_sts);
      chk_irqs;
      spr_wr(tev_pkg::SPR_STATUS, 32'hffff_ffff, 1'b1);
      // watchdog arm, seen, forced reset; then fixed interval
      spr_wr(tev_pkg::SPR_CONTROL, 32'h3880_0000, 1'b1);
      rd_chk("control", tev_pkg::SPR_CONTROL, m_ctl);
      for (int i = 0; i < 3; i++) rise(16);
      rise(8);
      spr_wr(tev_pkg::SPR_STATUS, 32'hffff_ffff, 1'b1);
      rd_chk("status", tev_pkg::SPR_STATUS, m_sts);
      spr_wr(tev_pkg::SPR_CONTROL, 32'h0040_0000, 1'b1);
      rd_chk("control", tev_pkg::SPR_CONTROL, m_ctl);
      // a second reset clears the sticky kind and auto-reload
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      m_ctl = '0;
      m_sts = '0;
      m_cnt = '0;
      m_rld = '0;
      @(negedge mclk);
      rd_chk("control", tev_pkg::SPR_CONTROL, m_ctl);
      rd_chk("status", tev_pkg::SPR_STATUS, m_sts);
      rd_chk("countdown", tev_pkg::SPR_COUNTDOWN, m_cnt);
      spr_wr(tev_pkg::SPR_COUNTDOWN, 32'h0000_0001, 1'b1);
      repeat (2) tick;
      rd_chk("countdown", tev_pkg::SPR_COUNTDOWN, m_cnt);
      rd_chk("status", tev_pkg::SPR_STATUS, m_sts);
      tally_and_finish;
   end
endmodule
